// ### cvas_pkg.sv
// Constants shared by the converter setup register bank and its helpers.
// Assumes byte-wide registers on a byte-addressed host register port.
package cvas_pkg;

  // ----------------------------------------------------------------
  // Register port widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // Byte offsets; multi-byte registers keep the low byte first
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_POS_B0 = 8'h2c;
  localparam logic [7:0] OFF_POS_B1 = 8'h2d;
  localparam logic [7:0] OFF_POS_B2 = 8'h2e;
  localparam logic [7:0] OFF_FSA_LO = 8'h30;
  localparam logic [7:0] OFF_FSA_HI = 8'h31;
  localparam logic [7:0] OFF_FSB_LO = 8'h32;
  localparam logic [7:0] OFF_FSB_HI = 8'h33;
  localparam logic [7:0] OFF_BYPASS = 8'h38;
  localparam logic [7:0] OFF_STAMP = 8'h3b;
  localparam logic [7:0] OFF_SERPE = 8'h48;
  localparam logic [7:0] OFF_INMUX = 8'h60;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [23:0] RST_POS = 24'h00_0000;
  localparam logic [15:0] RST_FS = 16'ha000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_INMUX = 8'h01;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_BYPASS = 0;
  localparam int BIT_RECV = 0;
  localparam int BIT_PECL = 1;
  localparam int BIT_BOOST = 3;
  localparam int BIT_SWAP = 4;
  localparam int PE_MSB = 2;
  localparam int SEL_MSB = 1;

  // ----------------------------------------------------------------
  // Single-channel input selection codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CVAS_SEL_RSVD = 2'h0,
    CVAS_SEL_INA = 2'h1,
    CVAS_SEL_INB = 2'h2,
    CVAS_SEL_OWN = 2'h3
  } cvas_sel_t;

  // Address match helper used by every register decode.
  function automatic logic cvas_hit(input logic [7:0] addr, input logic [7:0] off);
    cvas_hit = (addr == off);
  endfunction

endpackage

// ### cvas_route_if.sv
// Carrier between the register bank and its input routing helper.
// Assumes both ends share the bank clock.
`timescale 1ns/1ps
`default_nettype none
interface cvas_route_if;
  logic single_mode;
  logic dual_swap;
  logic [1:0] single_sel;
  logic core_a_src_b;
  logic core_b_src_b;
  modport route (
    input single_mode,
    input dual_swap,
    input single_sel,
    output core_a_src_b,
    output core_b_src_b
  );
  modport bank (
    output single_mode,
    output dual_swap,
    output single_sel,
    input core_a_src_b,
    input core_b_src_b
  );
endinterface
`default_nettype wire

// ### cvas_input_route.sv
// Decides which analog input each converter core samples.
// Assumes mode and selection come from the register bank over the carrier.
`timescale 1ns/1ps
`default_nettype none
module cvas_input_route
  import cvas_pkg::*;
(
  cvas_route_if.route rt
);

  // ----------------------------------------------------------------
  // Routing decode
  // ----------------------------------------------------------------
  // Single mode picks one input for both cores, or each core its own.
  wire logic sel_b = (rt.single_sel == CVAS_SEL_INB);
  wire logic sel_own = (rt.single_sel == CVAS_SEL_OWN);
  // Core A takes input B in single mode when B is chosen, in dual mode when swap is set.
  assign rt.core_a_src_b = rt.single_mode ? sel_b : rt.dual_swap; // R12 R13
  // Core B takes input B in single mode for a B pick or its own input, in dual mode when swap is clear.
  assign rt.core_b_src_b = rt.single_mode ? (sel_b | sel_own) : ~rt.dual_swap; // R12 R13

endmodule
`default_nettype wire

// ### cvas_sysref_capture.sv
// Holds the last captured SYSREF edge position word.
// Assumes the detector presents its word with a one-cycle capture strobe.
`timescale 1ns/1ps
`default_nettype none
module cvas_sysref_capture
  import cvas_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic capture,
  input wire logic [23:0] sample,
  output logic [23:0] position
);

  // ----------------------------------------------------------------
  // Capture register
  // ----------------------------------------------------------------
  logic [23:0] pos_r;
  wire logic [23:0] pos_nxt = capture ? sample : pos_r;

  // Keeps the word stable between captures so software reads are coherent.
  always_ff @(posedge clk) begin
    if (reset) begin
      pos_r <= RST_POS;
    end else begin
      pos_r <= pos_nxt; // R1
    end
  end

  assign position = pos_r;

endmodule
`default_nettype wire

// ### cvas_setup_regs.sv
// Configuration and status register bank of the converter analog setup.
// Assumes a synchronous host port: one-cycle strobes, read data next cycle.
//
// How it works
// R1 - A 24-bit SYSREF edge position word is readable by software.
// R2 - Software reads that word to pick the SYSREF delay choice.
// R3 - Input A full-scale code resets to 0xA000; 0x2000 to 0xFFFF spans range.
// R4 - Input B full-scale code is separate, same encoding, resets 0xA000.
// R5 - Software keeps full-scale codes at or above 0x2000.
// R6 - Reference bypass bit 0 selects the analog core supply as reference.
// R7 - Stamp input PECL enable at bit 1, resets to zero.
// R8 - Stamp receiver enable at bit 0 turns the receiver on, resets zero.
// R9 - Three-bit pre-emphasis field drives all sixteen lanes, resets zero.
// R10 - Boost bit 3 raises and lengthens lane pre-emphasis.
// R11 - Input selector resets 0x01: swap bit 4, single select bits 1:0.
// R12 - In dual modes swap set exchanges inputs between channels.
// R13 - Single mode: 1 samples A, 2 samples B, 3 each core its own.
// R14 - Reserved bits reset zero, read zero and change nothing.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module cvas_setup_regs
  import cvas_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sysref_capture,
  input wire logic [23:0] sysref_sample,
  input wire logic single_chan_mode,
  output logic [15:0] fullscale_code_chan_a,
  output logic [15:0] fullscale_code_chan_b,
  output logic reference_bypass,
  output logic stamp_receiver_enable,
  output logic stamp_input_pecl_enable,
  output logic [2:0] serializer_preemphasis,
  output logic preemphasis_boost,
  output logic core_a_samples_b,
  output logic core_b_samples_b
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0] fs_a_r;
  logic [15:0] fs_b_r;
  logic bypass_r;
  logic recv_r;
  logic pecl_r;
  logic [2:0] pe_r;
  logic boost_r;
  logic swap_r;
  logic [1:0] sel_r;
  logic [7:0] rdata_r;
  logic core_a_r;
  logic core_b_r;
  logic [23:0] pos;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  cvas_route_if rt ();

  assign rt.single_mode = single_chan_mode;
  assign rt.dual_swap = swap_r;
  assign rt.single_sel = sel_r;

  cvas_input_route u_route (
    .rt(rt)
  );

  cvas_sysref_capture u_capture (
    .clk(clk),
    .reset(reset),
    .capture(sysref_capture),
    .sample(sysref_sample),
    .position(pos)
  );

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Each strobe hits one byte; unmapped writes fall through unused.
  wire logic wr_fsa_lo = reg_wr & cvas_hit(reg_addr, OFF_FSA_LO);
  wire logic wr_fsa_hi = reg_wr & cvas_hit(reg_addr, OFF_FSA_HI);
  wire logic wr_fsb_lo = reg_wr & cvas_hit(reg_addr, OFF_FSB_LO);
  wire logic wr_fsb_hi = reg_wr & cvas_hit(reg_addr, OFF_FSB_HI);
  wire logic wr_bypass = reg_wr & cvas_hit(reg_addr, OFF_BYPASS);
  wire logic wr_stamp = reg_wr & cvas_hit(reg_addr, OFF_STAMP);
  wire logic wr_serpe = reg_wr & cvas_hit(reg_addr, OFF_SERPE);
  wire logic wr_inmux = reg_wr & cvas_hit(reg_addr, OFF_INMUX);

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  // Only defined field bits are taken; reserved write bits are dropped.
  wire logic [15:0] fs_a_nxt = {wr_fsa_hi ? reg_wdata : fs_a_r[15:8],
                                wr_fsa_lo ? reg_wdata : fs_a_r[7:0]}; // R3
  wire logic [15:0] fs_b_nxt = {wr_fsb_hi ? reg_wdata : fs_b_r[15:8],
                                wr_fsb_lo ? reg_wdata : fs_b_r[7:0]}; // R4
  wire logic bypass_nxt = wr_bypass ? reg_wdata[BIT_BYPASS] : bypass_r; // R6
  wire logic recv_nxt = wr_stamp ? reg_wdata[BIT_RECV] : recv_r; // R8
  wire logic pecl_nxt = wr_stamp ? reg_wdata[BIT_PECL] : pecl_r; // R7
  wire logic [2:0] pe_nxt = wr_serpe ? reg_wdata[PE_MSB:0] : pe_r; // R9
  wire logic boost_nxt = wr_serpe ? reg_wdata[BIT_BOOST] : boost_r; // R10
  wire logic swap_nxt = wr_inmux ? reg_wdata[BIT_SWAP] : swap_r; // R11
  wire logic [1:0] sel_nxt = wr_inmux ? reg_wdata[SEL_MSB:0] : sel_r; // R11 R14

  // ----------------------------------------------------------------
  // Read selection
  // ----------------------------------------------------------------
  // Reserved bits and unmapped offsets return zero.
  wire logic [7:0] rd_bypass = {7'h00, bypass_r}; // R14
  wire logic [7:0] rd_stamp = {6'h00, pecl_r, recv_r}; // R14
  wire logic [7:0] rd_serpe = {4'h0, boost_r, pe_r}; // R14
  wire logic [7:0] rd_inmux = {3'h0, swap_r, 2'h0, sel_r}; // R14
  wire logic [7:0] rd_mux =
    cvas_hit(reg_addr, OFF_POS_B0) ? pos[7:0] :
    cvas_hit(reg_addr, OFF_POS_B1) ? pos[15:8] :
    cvas_hit(reg_addr, OFF_POS_B2) ? pos[23:16] : // R1
    cvas_hit(reg_addr, OFF_FSA_LO) ? fs_a_r[7:0] :
    cvas_hit(reg_addr, OFF_FSA_HI) ? fs_a_r[15:8] :
    cvas_hit(reg_addr, OFF_FSB_LO) ? fs_b_r[7:0] :
    cvas_hit(reg_addr, OFF_FSB_HI) ? fs_b_r[15:8] :
    cvas_hit(reg_addr, OFF_BYPASS) ? rd_bypass :
    cvas_hit(reg_addr, OFF_STAMP) ? rd_stamp :
    cvas_hit(reg_addr, OFF_SERPE) ? rd_serpe :
    cvas_hit(reg_addr, OFF_INMUX) ? rd_inmux : RST_BYTE;
  // Read data stand only in the cycle after the strobe.
  wire logic [7:0] rdata_nxt = reg_rd ? rd_mux : RST_BYTE;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Configuration fields load their reset values on a synchronous reset.
  always_ff @(posedge clk) begin
    if (reset) begin
      fs_a_r <= RST_FS; // R3
      fs_b_r <= RST_FS; // R4
      bypass_r <= RST_BYTE[BIT_BYPASS]; // R6
      recv_r <= RST_BYTE[BIT_RECV]; // R8
      pecl_r <= RST_BYTE[BIT_PECL]; // R7
      pe_r <= RST_BYTE[PE_MSB:0]; // R9
      boost_r <= RST_BYTE[BIT_BOOST]; // R10
      swap_r <= RST_INMUX[BIT_SWAP]; // R11
      sel_r <= RST_INMUX[SEL_MSB:0]; // R11
    end else begin
      fs_a_r <= fs_a_nxt;
      fs_b_r <= fs_b_nxt;
      bypass_r <= bypass_nxt;
      recv_r <= recv_nxt;
      pecl_r <= pecl_nxt;
      pe_r <= pe_nxt;
      boost_r <= boost_nxt;
      swap_r <= swap_nxt;
      sel_r <= sel_nxt;
    end
  end

  // Read data and routing outputs are flopped so outputs leave a register.
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= RST_BYTE;
      core_a_r <= 1'b0;
      core_b_r <= 1'b1;
    end else begin
      rdata_r <= rdata_nxt;
      core_a_r <= rt.core_a_src_b; // R12 R13
      core_b_r <= rt.core_b_src_b; // R12 R13
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = rdata_r;
  assign fullscale_code_chan_a = fs_a_r;
  assign fullscale_code_chan_b = fs_b_r;
  assign reference_bypass = bypass_r;
  assign stamp_receiver_enable = recv_r;
  assign stamp_input_pecl_enable = pecl_r;
  assign serializer_preemphasis = pe_r;
  assign preemphasis_boost = boost_r;
  assign core_a_samples_b = core_a_r;
  assign core_b_samples_b = core_b_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_wr_fsa_lo;
    reg_wr && reg_addr == OFF_FSA_LO;
  endsequence

  sequence s_rd_fsa_lo;
    reg_rd && reg_addr == OFF_FSA_LO;
  endsequence

  // An input A low-byte write followed next cycle by its read returns the written byte.
  property p_fsa_wr_rd;
    logic [7:0] d;
    (s_wr_fsa_lo, d = reg_wdata) ##1 s_rd_fsa_lo |=> reg_rdata == d;
  endproperty
  a_fsa_wr_rd: assert property (p_fsa_wr_rd) else $error("fsa readback wrong"); // R3

  // The input B code leaves reset at its documented default.
  property p_fsb_reset;
    @(posedge clk) disable iff (1'b0) reset |=> fullscale_code_chan_b == RST_FS;
  endproperty
  a_fsb_reset: assert property (p_fsb_reset) else $error("fsb reset wrong"); // R4

  // A read of position byte 1 returns that byte as held when the strobe came.
  property p_pos_read;
    reg_rd && reg_addr == OFF_POS_B1 |=> reg_rdata == $past(pos[15:8]);
  endproperty
  a_pos_read: assert property (p_pos_read) else $error("position read wrong"); // R1

  // The bypass output follows bit 0 of a write to its register.
  property p_bypass_wr;
    reg_wr && reg_addr == OFF_BYPASS |=> reference_bypass == $past(reg_wdata[0]);
  endproperty
  a_bypass_wr: assert property (p_bypass_wr) else $error("bypass not taken"); // R6

  // Stamp control bits take their own write bits.
  property p_stamp_wr;
    reg_wr && reg_addr == OFF_STAMP |=>
      stamp_input_pecl_enable == $past(reg_wdata[1]) &&
      stamp_receiver_enable == $past(reg_wdata[0]);
  endproperty
  a_stamp_wr: assert property (p_stamp_wr) else $error("stamp bits wrong"); // R7 R8

  // Pre-emphasis field and boost take their write bits together.
  property p_serpe_wr;
    reg_wr && reg_addr == OFF_SERPE |=>
      serializer_preemphasis == $past(reg_wdata[2:0]) &&
      preemphasis_boost == $past(reg_wdata[3]);
  endproperty
  a_serpe_wr: assert property (p_serpe_wr) else $error("emphasis wrong"); // R9 R10

  // The selector holds 0x01 in the first cycle after reset.
  property p_inmux_reset;
    $fell(reset) |-> rd_inmux == RST_INMUX;
  endproperty
  a_inmux_reset: assert property (p_inmux_reset) else $error("selector reset"); // R11

  // Dual mode with swap set routes B to core A and A to core B.
  property p_dual_swap;
    !single_chan_mode && swap_r |=> core_a_samples_b && !core_b_samples_b;
  endproperty
  a_dual_swap: assert property (p_dual_swap) else $error("swap route wrong"); // R12

  // Single mode selection 2 puts both cores on input B.
  property p_single_b;
    single_chan_mode && sel_r == CVAS_SEL_INB |=> core_a_samples_b && core_b_samples_b;
  endproperty
  a_single_b: assert property (p_single_b) else $error("single B route wrong"); // R13

  // Reserved bits of the stamp register always read zero.
  property p_rsvd_zero;
    reg_rd && reg_addr == OFF_STAMP |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set"); // R14

  // The input A code leaves reset at its default.
  property p_fsa_reset;
    @(posedge clk) disable iff (1'b0) reset |=> fullscale_code_chan_a == RST_FS;
  endproperty
  a_fsa_reset: assert property (p_fsa_reset) else $error("fsa reset wrong"); // R3

  // A selector write takes the swap bit and the selection field.
  property p_inmux_wr;
    reg_wr && reg_addr == OFF_INMUX |=>
      swap_r == $past(reg_wdata[BIT_SWAP]) &&
      sel_r == $past(reg_wdata[SEL_MSB:0]);
  endproperty
  a_inmux_wr: assert property (p_inmux_wr) else $error("selector write wrong"); // R11

  // Routing leaves reset on the direct dual mapping.
  property p_route_reset;
    $fell(reset) |-> !core_a_samples_b && core_b_samples_b;
  endproperty
  a_route_reset: assert property (p_route_reset) else $error("route reset wrong"); // R12

  // Dual mode without swap keeps each input on its own channel.
  property p_dual_direct;
    !single_chan_mode && !swap_r |=> !core_a_samples_b && core_b_samples_b;
  endproperty
  a_dual_direct: assert property (p_dual_direct) else $error("direct route wrong"); // R12

  // Single mode selection 1 puts both cores on input A.
  property p_single_a;
    single_chan_mode && sel_r == CVAS_SEL_INA |=> !core_a_samples_b && !core_b_samples_b;
  endproperty
  a_single_a: assert property (p_single_a) else $error("single A route wrong"); // R13

  // Single mode selection 3 lets each core sample its own input.
  property p_single_own;
    single_chan_mode && sel_r == CVAS_SEL_OWN |=> !core_a_samples_b && core_b_samples_b;
  endproperty
  a_single_own: assert property (p_single_own) else $error("single own route wrong"); // R13

  // A capture strobe loads the detector word into the position register.
  property p_capture_load;
    sysref_capture |=> pos == $past(sysref_sample);
  endproperty
  a_capture_load: assert property (p_capture_load) else $error("capture not loaded"); // R1

  // Without a capture strobe the position word holds, so byte reads stay coherent.
  property p_pos_hold;
    !reset && !sysref_capture |=> $stable(pos);
  endproperty
  a_pos_hold: assert property (p_pos_hold) else $error("position word moved"); // R1

endmodule
`default_nettype wire

// ### cvas_setup_regs_test.sv
// Self-checking testbench of the converter setup register bank.
// Assumes the bank's host port answers reads one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module cvas_setup_regs_test
  import cvas_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic sysref_capture = 1'b0;
  logic [23:0] sysref_sample = 24'h00_0000;
  logic single_chan_mode = 1'b0;
  logic [15:0] fs_a;
  logic [15:0] fs_b;
  logic byp, recv, pecl, boost, ca, cb;
  logic [2:0] pe;
  logic [7:0] exp_q[$];
  logic rd_d = 1'b0;
  logic [23:0] smp;
  logic [7:0] v;
  int n_fail = 0;
  int n_tests = 0;
  int seed = 34;
  logic [7:0] offs [8] = '{OFF_FSA_LO, OFF_FSA_HI, OFF_FSB_LO, OFF_FSB_HI, OFF_BYPASS,
                           OFF_STAMP, OFF_SERPE, OFF_INMUX};
  logic [7:0] msk [8] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h01, 8'h03, 8'h0f, 8'h13};
  logic [7:0] wv [8];

  // Free-running 250 MHz clock.
  initial begin
    forever #2 clk = ~clk;
  end

  cvas_setup_regs DUT (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sysref_capture(sysref_capture), .sysref_sample(sysref_sample),
    .single_chan_mode(single_chan_mode), .fullscale_code_chan_a(fs_a),
    .fullscale_code_chan_b(fs_b), .reference_bypass(byp), .stamp_receiver_enable(recv),
    .stamp_input_pecl_enable(pecl), .serializer_preemphasis(pe),
    .preemphasis_boost(boost), .core_a_samples_b(ca), .core_b_samples_b(cb)
  );

  // ----------------------------------------------------------------
  // Compare, drive and verdict tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask

  // Read data compare, one byte at a time.
  task automatic chk_rdata(input string name, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic results;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
  endtask

  // A read notes its expected data for the watcher.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    exp_q.push_back(e);
  endtask

  task automatic idle(input int n);
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Routing expectation as {core A on B, core B on B}.
  function automatic logic [1:0] rexp(input logic m, input logic [7:0] r);
    if (m) rexp = (r[1:0] == 2'h2) ? 2'b11 : (r[1:0] == 2'h3) ? 2'b01 : 2'b00;
    else rexp = r[4] ? 2'b10 : 2'b01;
  endfunction

  task automatic check_all;
    chk("fs_a", {wv[1], wv[0]}, fs_a);
    chk("fs_b", {wv[3], wv[2]}, fs_b);
    chk("bypass", {15'h0000, wv[4][0]}, {15'h0000, byp});
    chk("stamp", {14'h0000, wv[5][1:0]}, {14'h0000, pecl, recv});
    chk("preemph", {12'h000, wv[6][3:0]}, {12'h000, boost, pe});
    chk("route", {14'h0000, rexp(single_chan_mode, wv[7])}, {14'h0000, ca, cb});
  endtask

  task automatic read_all;
    for (int i = 0; i < 8; i++) rd(offs[i], wv[i]);
  endtask

  task automatic hold_reset;
    @(posedge clk);
    reset <= 1'b1;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    wv = '{8'h00, 8'ha0, 8'h00, 8'ha0, 8'h00, 8'h00, 8'h00, 8'h01};
    idle(1);
  endtask

  // Read data is compared in the cycle after each read strobe, else must be zero.
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) begin
    if (rd_d === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("MISMATCH reg_rdata expected none seen %h", reg_rdata);
      end else chk_rdata("reg_rdata", exp_q.pop_front(), reg_rdata);
    end else if (reset === 1'b0) chk_rdata("idle_rdata", 8'h00, reg_rdata);
  end

  // Hang guard.
  initial begin
    #100000;
    n_fail++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    hold_reset();
    check_all();
    read_all();
    for (int k = 0; k < 3; k++) rd(OFF_POS_B0 + k[7:0], 8'h00);
    // All-ones, all-zeros (0x20 in full-scale high bytes) and random values, reserved bits included.
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < 8; i++) begin
        v = (p == 0) ? 8'hff : (p == 1) ? 8'h00 : 8'($random(seed));
        if (i == 1 || i == 3) v = v | 8'h20;
        wr(offs[i], v);
        wv[i] = v & msk[i];
      end
      read_all();
      idle(3);
      check_all();
    end
    // Recommended minimum code, written then read back to back.
    wr(OFF_FSA_HI, 8'h20);
    wr(OFF_FSA_LO, 8'h00);
    rd(OFF_FSA_LO, 8'h00);
    rd(OFF_FSA_HI, 8'h20);
    wr(OFF_FSB_LO, 8'h00);
    wr(OFF_FSB_HI, 8'h20);
    wv[0:3] = '{8'h00, 8'h20, 8'h00, 8'h20};
    idle(2);
    check_all();
    // Every pre-emphasis and boost setting.
    for (int k = 0; k < 16; k++) begin
      wr(OFF_SERPE, {4'hf, k[3:0]});
      wv[6] = {4'h0, k[3:0]};
      idle(2);
      check_all();
    end
    // Every selection code and swap value in both modes.
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      single_chan_mode <= m[0];
      for (int s = 0; s < 8; s++) begin
        v = {3'b111, s[2], 2'b11, s[1:0]};
        wr(OFF_INMUX, v);
        wv[7] = v & msk[7];
        idle(3);
        check_all();
      end
    end
    // Captured edge position, and writes to it ignored.
    smp = 24'($random(seed));
    @(posedge clk);
    sysref_sample <= smp;
    sysref_capture <= 1'b1;
    @(posedge clk);
    sysref_capture <= 1'b0;
    sysref_sample <= ~smp;
    for (int k = 0; k < 3; k++) rd(OFF_POS_B0 + k[7:0], smp[8*k +: 8]);
    wr(OFF_POS_B0, ~smp[7:0]);
    rd(OFF_POS_B0, smp[7:0]);
    // Unmapped places read zero and change nothing.
    wr(8'h34, 8'hff);
    wr(8'h39, 8'hff);
    rd(8'h34, 8'h00);
    rd(8'h39, 8'h00);
    rd(8'h61, 8'h00);
    read_all();
    idle(2);
    check_all();
    // A second reset restores every value.
    hold_reset();
    check_all();
    read_all();
    idle(2);
    for (int t = 0; t < 8 && exp_q.size() != 0; t++) idle(1);
    if (exp_q.size() != 0) n_fail++;
    results();
  end
endmodule
`default_nettype wire
